// *** design/adc_ctl_pkg.sv ***
// Constants shared by the converter control block and its sequencer
// Function
// (RULE1) Result read wins; store new result afterwards
// (RULE2) Config write at end drops result, no interrupt
// (RULE3) Channel rewrite never clears the end flag
// (RULE4) Old channel result may land before rewrite
// (RULE5) Software clears end flag before resuming conversion
// (RULE6) Software clears start bit before STOP mode
// (RULE7) Clearing enable with start powers comparator down
// (RULE8) Standby restart: clear end flag, then start
// (RULE9) Start within 1 us of enable: suspect result
// (RULE10) Config or port writes may spoil result registers
// (RULE11) Software reads result before config writes
// (RULE12) 1.45 V reference only in high-speed main mode
// (RULE13) No pin changes during conversion
// (RULE14) Conversion time spans sampling through digital output
// (RULE15) 10-bit result, high byte view, end-only update
package adc_ctl_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [3:0] OFS_MODE0 = 4'h0;
  localparam logic [3:0] OFS_CHAN = 4'h1;
  localparam logic [3:0] OFS_PORT_CFG = 4'h2;
  localparam logic [3:0] OFS_PORT_MODE = 4'h3;
  localparam logic [3:0] OFS_RESULT = 4'h4;
  localparam logic [3:0] OFS_RESULT_HI = 4'h5;
  localparam logic [3:0] OFS_IRQ_FLAG = 4'h6;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h7;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  // ==========================================================
  // Field positions and widths
  localparam int START_BIT = 7;
  localparam int ENABLE_BIT = 0;
  localparam int END_FLAG_BIT = 0;
  localparam int RES_W = 10;
  localparam int CHAN_W = 5;
  localparam int PCFG_W = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_SAMPLING = 1;
  localparam int ST_VALID = 2;
  localparam int ST_SUSPECT = 3;
  localparam int ST_PENDING = 4;
  // ==========================================================
  // Reset values
  localparam logic [7:0] MODE0_RST = 8'h00;
  localparam logic [4:0] CHAN_RST = 5'h00;
  localparam logic [3:0] PCFG_RST = 4'h0;
  localparam logic [7:0] PMODE_RST = 8'hff;
  localparam logic [7:0] MASK_RST = 8'h00;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int STAB_TIME_NS = 1000;
  localparam int STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_TIME_NS = 1000;
  localparam int SAMPLE_CYCLES = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONVERT_CYCLES = RES_W + 2;
  localparam int CONV_TOTAL_CYCLES = SAMPLE_CYCLES + CONVERT_CYCLES;
  localparam int CNT_W = 8;
endpackage

// *** design/adc_core_if.sv ***
// Signals between the register side and the conversion sequencer
`timescale 1ns/1ps
interface adc_core_if;
  logic enable;
  logic start;
  logic done;
  logic sampling;
  logic busy;
  logic [9:0] code;
  modport ctl (output enable, output start, input done, input sampling, input busy, input code);
  modport core (input enable, input start, output done, output sampling, output busy, output code);
endinterface

// *** design/adc_seq_core.sv ***
// Conversion sequencer: sampling interval, successive approximation, end pulse
`timescale 1ns/1ps
module adc_seq_core (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Comparator code from the approximation logic
  input wire logic [9:0] i_sar_code,
  // Control link
  adc_core_if.core lnk
);
  typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT, FINISH} seq_state_type;
  seq_state_type state_q;
  logic [adc_ctl_pkg::CNT_W-1:0] cnt_q;
  logic done_q;
  logic [9:0] code_q;
  logic run;

  // Running needs both enable and start
  assign run = lnk.enable && lnk.start;

  // ==========================================================
  // Sequencer; conversion time counted from sampling to output
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_q <= IDLE;
      cnt_q <= '0;
    end
    else if (!run)
    begin
      state_q <= IDLE; // Start bit cleared aborts any conversion [RULE6] [RULE7]
      cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        IDLE:
        begin
          state_q <= SAMPLE;
          cnt_q <= '0;
        end
        SAMPLE:
        begin
          if (cnt_q == adc_ctl_pkg::CNT_W'(adc_ctl_pkg::SAMPLE_CYCLES - 1))
          begin
            state_q <= CONVERT; // Sampling is part of conversion time [RULE14]
            cnt_q <= '0;
          end
          else
          begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        CONVERT:
        begin
          if (cnt_q == adc_ctl_pkg::CNT_W'(adc_ctl_pkg::CONVERT_CYCLES - 1))
          begin
            state_q <= FINISH;
          end
          else
          begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default:
        begin
          state_q <= SAMPLE; // Repeat while start stays set
          cnt_q <= '0;
        end
      endcase
    end
  end

  // End pulse and captured code
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      done_q <= 1'b0;
      code_q <= '0;
    end
    else
    begin
      done_q <= run && state_q == CONVERT
        && cnt_q == adc_ctl_pkg::CNT_W'(adc_ctl_pkg::CONVERT_CYCLES - 1); // [RULE14]
      if (run && state_q == CONVERT)
      begin
        code_q <= i_sar_code;
      end
    end
  end

  assign lnk.done = done_q;
  assign lnk.code = code_q;
  assign lnk.sampling = state_q == SAMPLE;
  assign lnk.busy = state_q != IDLE;
endmodule

// *** design/adc_result_conflict_control.sv ***
// Converter control: registers, result arbitration, end flag and interrupt
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module adc_result_conflict_control (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [9:0] o_rdata,
  // Approximation logic
  input wire logic [9:0] i_sar_code,
  // Analog controls
  output logic o_comp_power,
  output logic o_sample_switch,
  output logic [4:0] o_chan_sel,
  output logic [3:0] o_port_cfg,
  output logic [7:0] o_port_mode,
  // Interrupt
  output logic o_irq
);
  adc_core_if lnk ();

  // ==========================================================
  // Register state
  logic [7:0] mode0_q;
  logic [4:0] chan_q;
  logic [3:0] pcfg_q;
  logic [7:0] pmode_q;
  logic [9:0] result_q;
  logic [9:0] pend_code_q;
  logic pend_q;
  logic valid_q;
  logic end_flag_q;
  logic [7:0] mask_q;
  logic [adc_ctl_pkg::CNT_W-1:0] stab_q;
  logic early_q;
  logic suspect_q;
  logic [9:0] rdata_q;
  logic irq_q;
  logic power_q;
  logic sample_q;

  // ==========================================================
  // Address decode
  logic wr_mode;
  logic wr_chan;
  logic wr_pcfg;
  logic wr_pmode;
  logic wr_flag;
  logic wr_mask;
  logic rd_res;
  logic cfg_wr;
  logic store;
  logic stab_done;
  logic start_wr;

  always_comb
  begin
    wr_mode = 1'b0;
    wr_chan = 1'b0;
    wr_pcfg = 1'b0;
    wr_pmode = 1'b0;
    wr_flag = 1'b0;
    wr_mask = 1'b0;
    if (i_wr)
    begin
      if (i_addr == adc_ctl_pkg::OFS_MODE0)
      begin
        wr_mode = 1'b1;
      end
      else if (i_addr == adc_ctl_pkg::OFS_CHAN)
      begin
        wr_chan = 1'b1;
      end
      else if (i_addr == adc_ctl_pkg::OFS_PORT_CFG)
      begin
        wr_pcfg = 1'b1;
      end
      else if (i_addr == adc_ctl_pkg::OFS_PORT_MODE)
      begin
        wr_pmode = 1'b1;
      end
      else if (i_addr == adc_ctl_pkg::OFS_IRQ_FLAG)
      begin
        wr_flag = 1'b1;
      end
      else if (i_addr == adc_ctl_pkg::OFS_IRQ_MASK)
      begin
        wr_mask = 1'b1;
      end
    end
  end

  // Result reads and the writes that override an end of conversion
  assign rd_res = i_rd && (i_addr == adc_ctl_pkg::OFS_RESULT
    || i_addr == adc_ctl_pkg::OFS_RESULT_HI);
  assign cfg_wr = wr_mode || wr_chan || wr_pcfg; // [RULE2]
  assign store = lnk.done && !cfg_wr; // Config write wins, result dropped [RULE2]
  assign stab_done = stab_q == adc_ctl_pkg::CNT_W'(adc_ctl_pkg::STAB_CYCLES);
  assign start_wr = wr_mode && i_wdata[adc_ctl_pkg::START_BIT]
    && !mode0_q[adc_ctl_pkg::START_BIT];

  // ==========================================================
  // Control registers written by software
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      mode0_q <= adc_ctl_pkg::MODE0_RST;
    end
    else if (wr_mode)
    begin
      mode0_q <= i_wdata; // Software stops here before STOP mode [RULE6]
    end
  end

  // Channel select; the end flag is not touched here [RULE3]
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      chan_q <= adc_ctl_pkg::CHAN_RST;
    end
    else if (wr_chan)
    begin
      chan_q <= i_wdata[adc_ctl_pkg::CHAN_W-1:0]; // Takes effect next cycle [RULE4]
    end
  end

  // Port configuration and port mode control
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pcfg_q <= adc_ctl_pkg::PCFG_RST;
      pmode_q <= adc_ctl_pkg::PMODE_RST;
    end
    else
    begin
      if (wr_pcfg)
      begin
        pcfg_q <= i_wdata[adc_ctl_pkg::PCFG_W-1:0];
      end
      if (wr_pmode)
      begin
        pmode_q <= i_wdata;
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      mask_q <= adc_ctl_pkg::MASK_RST;
    end
    else if (wr_mask)
    begin
      mask_q <= i_wdata;
    end
  end

  // ==========================================================
  // Sequencer link
  assign lnk.enable = mode0_q[adc_ctl_pkg::ENABLE_BIT];
  assign lnk.start = mode0_q[adc_ctl_pkg::START_BIT];

  adc_seq_core seq (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_sar_code (i_sar_code),
    .lnk (lnk.core)
  );

  // ==========================================================
  // Result register with read priority
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      result_q <= '0;
      pend_q <= 1'b0;
      pend_code_q <= '0;
    end
    else if (store && rd_res)
    begin
      pend_q <= 1'b1; // Read served first, store deferred [RULE1]
      pend_code_q <= lnk.code;
    end
    else if (store)
    begin
      result_q <= lnk.code; // Updated only at end of conversion [RULE15]
      pend_q <= 1'b0;
    end
    else if (pend_q)
    begin
      result_q <= pend_code_q; // Deferred store after the read [RULE1]
      pend_q <= 1'b0;
    end
  end

  // Result validity; configuration and port writes spoil it
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      valid_q <= 1'b0;
    end
    else if (store)
    begin
      valid_q <= 1'b1; // Old channel result may still land [RULE4]
    end
    else if (cfg_wr || wr_pmode)
    begin
      valid_q <= 1'b0; // Content no longer trusted [RULE10] [RULE11]
    end
  end

  // ==========================================================
  // End flag: set wins over a write-one clear
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      end_flag_q <= 1'b0;
    end
    else if (store)
    begin
      end_flag_q <= 1'b1; // No set when a config write collides [RULE2]
    end
    else if (wr_flag && i_wdata[adc_ctl_pkg::END_FLAG_BIT])
    begin
      end_flag_q <= 1'b0; // Cleared before restart [RULE5] [RULE8]
    end
  end

  // ==========================================================
  // Stabilisation after enable and early start detection
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      stab_q <= '0;
    end
    else if (!mode0_q[adc_ctl_pkg::ENABLE_BIT])
    begin
      stab_q <= '0;
    end
    else if (!stab_done)
    begin
      stab_q <= stab_q + 1'b1; // Counts the 1 us settle time [RULE9]
    end
  end

  // Early start marks the next result as suspect
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      early_q <= 1'b0;
      suspect_q <= 1'b0;
    end
    else
    begin
      if (start_wr && (!stab_done || !mode0_q[adc_ctl_pkg::ENABLE_BIT]))
      begin
        early_q <= 1'b1; // Start within settle time [RULE9]
      end
      else if (store)
      begin
        early_q <= 1'b0;
      end
      if (store)
      begin
        suspect_q <= early_q; // First result flagged for discard [RULE9]
      end
    end
  end

  // ==========================================================
  // Read data, valid only in the cycle after the read strobe
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rdata_q <= '0;
    end
    else if (!i_rd)
    begin
      rdata_q <= '0;
    end
    else if (i_addr == adc_ctl_pkg::OFS_MODE0)
    begin
      rdata_q <= {2'h0, mode0_q};
    end
    else if (i_addr == adc_ctl_pkg::OFS_CHAN)
    begin
      rdata_q <= {5'h00, chan_q};
    end
    else if (i_addr == adc_ctl_pkg::OFS_PORT_CFG)
    begin
      rdata_q <= {6'h00, pcfg_q};
    end
    else if (i_addr == adc_ctl_pkg::OFS_PORT_MODE)
    begin
      rdata_q <= {2'h0, pmode_q};
    end
    else if (i_addr == adc_ctl_pkg::OFS_RESULT)
    begin
      rdata_q <= result_q; // Old value when colliding with a store [RULE1] [RULE15]
    end
    else if (i_addr == adc_ctl_pkg::OFS_RESULT_HI)
    begin
      rdata_q <= {2'h0, result_q[9:2]}; // High-order byte view [RULE15]
    end
    else if (i_addr == adc_ctl_pkg::OFS_IRQ_FLAG)
    begin
      rdata_q <= {9'h000, end_flag_q};
    end
    else if (i_addr == adc_ctl_pkg::OFS_IRQ_MASK)
    begin
      rdata_q <= {2'h0, mask_q};
    end
    else if (i_addr == adc_ctl_pkg::OFS_STATUS)
    begin
      rdata_q <= {5'h00, pend_q, suspect_q, valid_q, lnk.sampling, lnk.busy};
    end
    else
    begin
      rdata_q <= '0; // Unmapped reads return zero
    end
  end

  // ==========================================================
  // Interrupt and analog control outputs
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      irq_q <= 1'b0;
      power_q <= 1'b0;
      sample_q <= 1'b0;
    end
    else
    begin
      irq_q <= end_flag_q && mask_q[adc_ctl_pkg::END_FLAG_BIT];
      power_q <= mode0_q[adc_ctl_pkg::ENABLE_BIT]; // Off when enable cleared [RULE7]
      sample_q <= lnk.sampling; // Switch closed only while sampling [RULE13]
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq = irq_q;
  assign o_comp_power = power_q;
  assign o_sample_switch = sample_q;
  assign o_chan_sel = chan_q;
  assign o_port_cfg = pcfg_q;
  assign o_port_mode = pmode_q;
endmodule

// *** verif/adc_ctl_props.sv ***
// Port checker for the converter control block
`timescale 1ns/1ps
module adc_ctl_props (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [9:0] o_rdata,
  // Converter side and interrupt
  input wire logic o_comp_power,
  input wire logic [4:0] o_chan_sel,
  input wire logic [3:0] o_port_cfg,
  input wire logic [7:0] o_port_mode,
  input wire logic o_irq
);
  // ==========================================================
  // Clocking shared by all checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);
  rdata_idle_a: assert property (!i_rd |=> o_rdata == 10'h000)
    else $error("read data not zero outside a read");
  comp_power_a: assert property (i_wr && i_addr == adc_ctl_pkg::OFS_MODE0 ##1
    !(i_wr && i_addr == adc_ctl_pkg::OFS_MODE0) |=> o_comp_power == $past(i_wdata[0], 2))
    else $error("comparator power does not follow enable");
  chan_sel_a: assert property (i_wr && i_addr == adc_ctl_pkg::OFS_CHAN
    |=> o_chan_sel == $past(i_wdata[4:0])) else $error("channel select not taken");
  port_cfg_a: assert property (i_wr && i_addr == adc_ctl_pkg::OFS_PORT_CFG
    |=> o_port_cfg == $past(i_wdata[3:0])) else $error("port config not taken");
  port_mode_a: assert property (i_wr && i_addr == adc_ctl_pkg::OFS_PORT_MODE
    |=> o_port_mode == $past(i_wdata)) else $error("port mode not taken");
  irq_clear_a: assert property ($fell(o_irq) |-> $past(i_wr) || $past(i_wr, 2))
    else $error("interrupt dropped without a write");
  irq_mask_a: assert property (i_wr && i_addr == adc_ctl_pkg::OFS_IRQ_MASK && !i_wdata[0]
    ##1 !(i_wr && i_addr == adc_ctl_pkg::OFS_IRQ_MASK) |=> !o_irq)
    else $error("masked interrupt still high");
  chan_flag_a: assert property (o_irq && i_wr && i_addr == adc_ctl_pkg::OFS_CHAN
    && !$past(i_wr) |=> o_irq) else $error("channel write cleared end flag");
  hi_byte_a: assert property (i_rd && i_addr == adc_ctl_pkg::OFS_RESULT_HI
    |=> o_rdata[9:8] == 2'h0) else $error("high byte read too wide");
endmodule

bind adc_result_conflict_control adc_ctl_props adc_ctl_props_i (
  .i_clock(i_clock),
  .i_rst_b(i_rst_b),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .o_comp_power(o_comp_power),
  .o_chan_sel(o_chan_sel),
  .o_port_cfg(o_port_cfg),
  .o_port_mode(o_port_mode),
  .o_irq(o_irq)
);

// *** verif/testbench.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench;
  logic i_clock;
  logic i_rst_b;
  logic [3:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [9:0] o_rdata;
  logic [9:0] i_sar_code;
  logic o_comp_power;
  logic o_sample_switch;
  logic [4:0] o_chan_sel;
  logic [3:0] o_port_cfg;
  logic [7:0] o_port_mode;
  logic o_irq;
  logic [9:0] code;
  int num_errors;
  int checks_done;
  // Block under test
  adc_result_conflict_control adc_result_conflict_control_i (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_sar_code(i_sar_code),
    .o_comp_power(o_comp_power),
    .o_sample_switch(o_sample_switch),
    .o_chan_sel(o_chan_sel),
    .o_port_cfg(o_port_cfg),
    .o_port_mode(o_port_mode),
    .o_irq(o_irq)
  );
  // Clock at 25 MHz
  initial
  begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  // ==========================================================
  // Verdict and comparison
  task automatic stop_test();
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask
  // ==========================================================
  // Register bus: one cycle per call, settled 1 ns after the edge
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    i_sar_code <= code;
    #1;
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 4'h0, 8'h00);
  endtask
  task automatic rd(input logic [3:0] a, output logic [9:0] v);
    bus(1'b0, 1'b1, a, 8'h00);
    idle(1);
    v = o_rdata;
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    while (o_irq !== 1'b1)
    begin
      idle(1);
      n++;
      if (n > 200)
      begin
        chk(10'h000, 10'h001, "interrupt timeout");
        stop_test();
      end
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [9:0] v;
    chk({2'h0, o_port_mode}, 10'h0ff, "port mode reset");
    rd(4'hf, v);
    chk(v, 10'h000, "unmapped read");
    bus(1'b1, 1'b0, adc_ctl_pkg::OFS_PORT_MODE, 8'h5a);
    idle(1);
    chk({2'h0, o_port_mode}, 10'h05a, "port mode write");
    bus(1'b1, 1'b0, adc_ctl_pkg::OFS_PORT_CFG, 8'h09); // Pin function set while idle
    idle(1);
    chk({6'h00, o_port_cfg}, 10'h009, "port config write");
  endtask
  task automatic t_convert();
    logic [9:0] v;
    int n;
    code = 10'h2a7;
    bus(1'b1, 1'b0, adc_ctl_pkg::OFS_IRQ_MASK, 8'h01);
    bus(1'b1, 1'b0, adc_ctl_pkg::OFS_MODE0, 8'h81); // Reference select untouched
    wait_irq(n);
    chk({9'h0, n >= adc_ctl_pkg::CONV_TOTAL_CYCLES
      && n <= adc_ctl_pkg::CONV_TOTAL_CYCLES + 8}, 10'h001, "conversion time");
    chk({9'h0, o_comp_power}, 10'h001, "comparator on");
    chk({9'h0, o_sample_switch}, 10'h001, "next sampling started");
    rd(adc_ctl_pkg::OFS_RESULT, v);
    chk(v, 10'h2a7, "result");
    rd(adc_ctl_pkg::OFS_RESULT_HI, v);
    chk(v, 10'h0a9, "result high byte");
    rd(adc_ctl_pkg::OFS_STATUS, v);
    chk({9'h0, v[adc_ctl_pkg::ST_SUSPECT]}, 10'h001, "early start suspect");
    bus(1'b1, 1'b0, adc_ctl_pkg::OFS_MODE0, 8'h01);
    bus(1'b1, 1'b0, adc_ctl_pkg::OFS_IRQ_FLAG, 8'h01);
    idle(2);
    chk({9'h0, o_irq}, 10'h000, "flag cleared");
    chk({9'h0, o_sample_switch}, 10'h000, "sampling stops with start");
  endtask
  task automatic t_read_collide();
    logic [9:0] v;
    logic bad;
    int n;
    code = 10'h15c;
    bad = 1'b0;
    bus(1'b1, 1'b0, adc_ctl_pkg::OFS_MODE0, 8'h81);
    // Read every cycle so that one read meets the result store
    for (n = 0; n < 200 && o_irq !== 1'b1; n++)
    begin
      bus(1'b0, 1'b1, adc_ctl_pkg::OFS_RESULT, 8'h00);
      if (n > 0 && o_rdata !== 10'h2a7 && o_rdata !== 10'h15c)
        bad = 1'b1;
    end
    chk({9'h0, o_irq}, 10'h001, "end after reads");
    chk({9'h0, bad}, 10'h000, "read saw a torn result");
    rd(adc_ctl_pkg::OFS_RESULT, v);
    chk(v, 10'h15c, "result kept after read clash");
    rd(adc_ctl_pkg::OFS_STATUS, v);
    chk({9'h0, v[adc_ctl_pkg::ST_SUSPECT]}, 10'h000, "late start clean");
    bus(1'b1, 1'b0, adc_ctl_pkg::OFS_MODE0, 8'h01);
    bus(1'b1, 1'b0, adc_ctl_pkg::OFS_IRQ_FLAG, 8'h01);
  endtask
  task automatic t_write_collide();
    logic [9:0] v;
    int n;
    code = 10'h3e1;
    bus(1'b1, 1'b0, adc_ctl_pkg::OFS_MODE0, 8'h81);
    // A mode or channel write in every cycle, so each end meets one
    for (n = 0; n < 120; n++)
      bus(1'b1, 1'b0, n[0] ? adc_ctl_pkg::OFS_CHAN : adc_ctl_pkg::OFS_MODE0,
        n[0] ? 8'h03 : 8'h81); // Pin function left alone
    idle(2);
    chk({9'h0, o_irq}, 10'h000, "no interrupt on write clash");
    rd(adc_ctl_pkg::OFS_RESULT, v);
    chk(v, 10'h15c, "result dropped on write clash");
    wait_irq(n);
    rd(adc_ctl_pkg::OFS_RESULT, v);
    chk(v, 10'h3e1, "result after writes stop");
    bus(1'b1, 1'b0, adc_ctl_pkg::OFS_CHAN, 8'h05);
    idle(2);
    chk({9'h0, o_irq}, 10'h001, "flag kept on channel write");
    bus(1'b1, 1'b0, adc_ctl_pkg::OFS_IRQ_MASK, 8'h00);
    idle(2);
    chk({9'h0, o_irq}, 10'h000, "interrupt masked");
    bus(1'b1, 1'b0, adc_ctl_pkg::OFS_IRQ_MASK, 8'h01);
    bus(1'b1, 1'b0, adc_ctl_pkg::OFS_MODE0, 8'h00);
    idle(2);
    chk({9'h0, o_irq}, 10'h001, "flag sticky under mask");
    chk({9'h0, o_comp_power}, 10'h000, "comparator off");
    bus(1'b1, 1'b0, adc_ctl_pkg::OFS_IRQ_FLAG, 8'h01);
    idle(2);
    chk({9'h0, o_irq}, 10'h000, "flag cleared for restart");
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    num_errors = 0;
    checks_done = 0;
    code = 10'h000;
    i_rst_b = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_sar_code = 10'h000;
    repeat (5) @(posedge i_clock);
    i_rst_b <= 1'b1;
    t_reset();
    t_convert();
    t_read_collide();
    t_write_collide();
    stop_test();
  end
endmodule
